// [rtl/led_ctrl_defines.vh]
`ifndef LED_CTRL_DEFINES_VH
`define LED_CTRL_DEFINES_VH
`define OFS_OUTPUT_ENABLE 8'h10
`define OFS_DISPLAY_LEVEL 8'hA0
`define OFS_KEYPAD_LEVEL 8'hB0
`define RST_OUTPUT_ENABLE 8'h00
`define RST_DISPLAY_LEVEL 8'h00
`define RST_KEYPAD_LEVEL 8'h00
`define BIT_MAIN_ENABLE 0
`define BIT_SUB_ENABLE 1
`define BIT_KEYPAD_ENABLE 2
`define POS_MAIN_LEVEL 0
`define POS_SUB_LEVEL 4
`define CLK_HZ 50000000
`define PWM_HZ 10000
`define PWM_STEPS 16
`define PWM_SLOT_CYCLES (`CLK_HZ / (`PWM_HZ * `PWM_STEPS))
// Target address value is arbitrary
`define TARGET_ADDR 7'h2B
`endif

// [rtl/led_brightness_serial_control.v]
`timescale 1ns/100ps
`default_nettype none
`include "led_ctrl_defines.vh"
module led_brightness_serial_control #(
    parameter [6:0] TARGET_ADDR = `TARGET_ADDR,
    parameter integer SLOT_CYCLES = `PWM_SLOT_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg main_bank_sinks,
    output reg sub_bank_sinks,
    output reg keypad_sink,
    output reg [1:0] keypad_scale,
    output reg pump_gain_high,
    output reg bus_busy
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_REG = 5'h04;
    localparam [4:0] ST_DATA = 5'h08;
    localparam [4:0] ST_IGNORE = 5'h10;

    localparam integer NUM_BANKS = 2;
    localparam integer NUM_REGS = 3;
    localparam [3:0] BITS_PER_BYTE = 4'h8;
    localparam [3:0] ACK_SLOT = 4'h9;

    localparam [1:0] IDX_ENABLE = 2'h0;
    localparam [1:0] IDX_DISPLAY = 2'h1;
    localparam [1:0] IDX_KEYPAD = 2'h2;

    // Pin synchronisers; the third stage feeds only the edge detectors
    reg scl_s1_q;
    reg scl_s2_q;
    reg scl_s3_q;
    reg sda_s1_q;
    reg sda_s2_q;
    reg sda_s3_q;

    // Receive engine registers and their next values
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [3:0] bit_cnt_q;
    reg [3:0] bit_cnt_d;
    reg [7:0] shift_q;
    reg [7:0] shift_d;
    reg [7:0] reg_addr_q;
    reg [7:0] reg_addr_d;
    reg ack_q;
    reg ack_d;
    reg busy_d;
    reg wr_en;
    reg wr_hit;
    reg [1:0] wr_idx;

    // Register storage, one flip-flop entry per register
    reg [7:0] regs_q [0:NUM_REGS-1];

    // PWM timebase
    reg [15:0] slot_cnt_q;
    reg [15:0] slot_cnt_d;
    reg [3:0] phase_q;
    reg [3:0] phase_d;

    // Decoded conditions on the synchronised pins, the PWM timebase and the register words
    wire scl_rise;
    wire scl_fall;
    wire begin_cond;
    wire end_cond;
    wire [7:0] byte_in;
    wire addr_match;
    wire slot_end;
    wire [7:0] enable_reg;
    wire [7:0] display_reg;
    wire [7:0] keypad_reg;
    wire [NUM_BANKS-1:0] bank_en;
    wire [NUM_BANKS-1:0] bank_on;
    wire key_en;
    wire keypad_only;
    genvar gi;

    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign begin_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign end_cond = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign byte_in = {shift_q[6:0], sda_s2_q};
    assign addr_match = (shift_q[7:1] == TARGET_ADDR) & ~shift_q[0];
    assign slot_end = (slot_cnt_q == SLOT_CYCLES[15:0] - 16'h0001);
    // Register words seen by the output logic
    assign enable_reg = regs_q[IDX_ENABLE];
    assign display_reg = regs_q[IDX_DISPLAY];
    assign keypad_reg = regs_q[IDX_KEYPAD];
    assign bank_en[0] = enable_reg[`BIT_MAIN_ENABLE];
    assign bank_en[1] = enable_reg[`BIT_SUB_ENABLE];
    assign key_en = enable_reg[`BIT_KEYPAD_ENABLE];
    // Keypad alone needs the higher pump gain
    assign keypad_only = key_en & ~(|bank_en);

    // Synchronisers
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // Register select from the second byte; unmapped addresses write nothing
    always @* begin
        wr_hit = 1'b1;
        case (reg_addr_q)
            `OFS_OUTPUT_ENABLE: wr_idx = IDX_ENABLE;
            `OFS_DISPLAY_LEVEL: wr_idx = IDX_DISPLAY;
            `OFS_KEYPAD_LEVEL: wr_idx = IDX_KEYPAD;
            default: begin
                wr_idx = IDX_ENABLE;
                wr_hit = 1'b0;
            end
        endcase
    end

    // Next state of the receive engine; a begin outranks every bit event
    always @* begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        reg_addr_d = reg_addr_q;
        ack_d = ack_q;
        busy_d = bus_busy;
        wr_en = 1'b0;
        if (begin_cond) begin
            state_d = ST_ADDR;
            bit_cnt_d = 4'h0;
            ack_d = 1'b0;
            busy_d = 1'b1;
        end else if (end_cond) begin
            state_d = ST_IDLE;
            ack_d = 1'b0;
            busy_d = 1'b0;
        end else if (scl_rise && bit_cnt_q < BITS_PER_BYTE) begin
            shift_d = byte_in;
            bit_cnt_d = bit_cnt_q + 4'h1;
        end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
            bit_cnt_d = ACK_SLOT;
            case (state_q)
                ST_ADDR: begin
                    if (addr_match) begin
                        ack_d = 1'b1;
                        state_d = ST_REG;
                    end else begin
                        state_d = ST_IGNORE;
                    end
                end
                ST_REG: begin
                    reg_addr_d = shift_q;
                    ack_d = 1'b1;
                    state_d = ST_DATA;
                end
                ST_DATA: begin
                    ack_d = 1'b1;
                    wr_en = 1'b1;
                end
                default: begin
                    state_d = ST_IGNORE;
                end
            endcase
        end else if (scl_fall && bit_cnt_q == ACK_SLOT) begin
            ack_d = 1'b0;
            bit_cnt_d = 4'h0;
        end
    end

    // Engine registers
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            reg_addr_q <= 8'h00;
            ack_q <= 1'b0;
            bus_busy <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            reg_addr_q <= reg_addr_d;
            ack_q <= ack_d;
            bus_busy <= busy_d;
        end
    end

    // One entry per register, loaded from the data byte
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_reg
            localparam [1:0] IDX = gi;
            localparam [7:0] RST_VAL = (gi == 0) ? `RST_OUTPUT_ENABLE :
                (gi == 1) ? `RST_DISPLAY_LEVEL : `RST_KEYPAD_LEVEL;
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    regs_q[gi] <= RST_VAL;
                end else if (wr_en && wr_hit && wr_idx == IDX) begin
                    regs_q[gi] <= shift_q;
                end
            end
        end
    endgenerate

    // Acknowledge drive; the pin is open drain, so only the enable moves
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= ack_q;
        end
    end

    // Fixed-rate PWM timebase, sixteen slots per period
    always @* begin
        slot_cnt_d = slot_cnt_q + 16'h0001;
        phase_d = phase_q;
        if (slot_end) begin
            slot_cnt_d = 16'h0000;
            phase_d = phase_q + 4'h1;
        end
    end

    // PWM counters
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_cnt_q <= 16'h0000;
            phase_q <= 4'h0;
        end else begin
            slot_cnt_q <= slot_cnt_d;
            phase_q <= phase_d;
        end
    end

    // Per-bank duty compare: code n lights phases 0 to n
    generate
        for (gi = 0; gi < NUM_BANKS; gi = gi + 1) begin : g_bank
            localparam integer POS = (gi == 0) ? `POS_MAIN_LEVEL : `POS_SUB_LEVEL;
            wire [3:0] code;
            assign code = display_reg[POS +: 4];
            assign bank_on[gi] = bank_en[gi] & (phase_q <= code);
        end
    endgenerate

    // Sink controls and pump request, all registered
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_bank_sinks <= 1'b0;
            sub_bank_sinks <= 1'b0;
            keypad_sink <= 1'b0;
            keypad_scale <= 2'h0;
            pump_gain_high <= 1'b0;
        end else begin
            main_bank_sinks <= bank_on[0];
            sub_bank_sinks <= bank_on[1];
            keypad_sink <= key_en;
            keypad_scale <= keypad_reg[1:0];
            pump_gain_high <= keypad_only;
        end
    end
endmodule // led_brightness_serial_control
`default_nettype wire

// [verification/led_ctrl_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module led_ctrl_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic keypad_sink,
    input wire logic [1:0] keypad_scale,
    input wire logic pump_gain_high,
    input wire logic bus_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_low; sda_oe |-> !sda_out; endproperty
    a_low: assert property (p_low) else $error("ack not low");
    property p_su; $rose(sda_oe) |-> !scl_in; endproperty
    a_su: assert property (p_su) else $error("ack late");
    property p_hd; sda_oe && scl_in |=> sda_oe; endproperty
    a_hd: assert property (p_hd) else $error("ack dropped");
    property p_beg; $fell(sda_in) && scl_in |-> ##[1:4] bus_busy; endproperty
    a_beg: assert property (p_beg) else $error("no begin");
    property p_end; $rose(sda_in) && scl_in |-> ##[1:4] !bus_busy; endproperty
    a_end: assert property (p_end) else $error("no end");
    property p_kc; $changed(keypad_scale) |-> bus_busy; endproperty
    a_kc: assert property (p_kc) else $error("stray write");
    property p_gw; $changed(pump_gain_high) |-> bus_busy; endproperty
    a_gw: assert property (p_gw) else $error("stray gain");
    property p_gk; pump_gain_high |-> keypad_sink; endproperty
    a_gk: assert property (p_gk) else $error("gain no keypad");
    property p_ob; sda_oe |-> bus_busy; endproperty
    a_ob: assert property (p_ob) else $error("ack outside session");
    c_ack: cover property ($rose(sda_oe));
    c_gain: cover property ($rose(pump_gain_high));
    c_end: cover property ($fell(bus_busy));
endmodule // led_ctrl_props
bind led_brightness_serial_control led_ctrl_props chk (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .keypad_sink(keypad_sink), .keypad_scale(keypad_scale),
    .pump_gain_high(pump_gain_high), .bus_busy(bus_busy));
`default_nettype wire

// [verification/bus_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
module bus_ctl (
    input wire logic clk,
    input wire logic sda,
    output var logic scl_o = 1'b1,
    output var logic sda_o = 1'b1,
    output var logic done = 1'b0,
    output var logic [2:0] acks
);
    task automatic hc(input int n); repeat (n) @(posedge clk); endtask
    task automatic bt(input logic b, output logic r);
        sda_o <= b; hc(2);
        scl_o <= 1'b1; hc(1); r = sda; hc(2);
        scl_o <= 1'b0; hc(3);
    endtask
    task automatic xfer(input logic [23:0] w, input int nb, input logic stp);
        logic r;
        acks <= 3'h0;
        sda_o <= 1'b1; hc(4); scl_o <= 1'b1; hc(4);
        sda_o <= 1'b0; hc(4); scl_o <= 1'b0; hc(4);
        for (int i = 23; i >= 24 - 8 * nb; i--) begin
            bt(w[i], r);
            if (i % 8 == 0) begin bt(1'b1, r); acks[i / 8] <= !r; end
        end
        if (stp) begin sda_o <= 1'b0; hc(4); scl_o <= 1'b1; hc(4); sda_o <= 1'b1; end
        hc(4); done <= 1'b1; hc(1); done <= 1'b0;
    endtask
endmodule // bus_ctl
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, sys_rst = 1'b1, mv = 1'b0;
    logic [15:0] mval, exp_q[$];
    int error_cnt = 0, n_checks = 0, seed = 48;
    logic [7:0] d;
    wire scl, sdo, done, oe, so, mb, sb, ks, pg, busy;
    wire [2:0] acks;
    wire [1:0] kc;
    wire sda = sdo & ~(oe & ~so);
    always #10 clk = ~clk;
    bus_ctl ctl (.clk(clk), .sda(sda), .scl_o(scl), .sda_o(sdo), .done(done), .acks(acks));
    led_brightness_serial_control #(.SLOT_CYCLES(2)) uut (.clk(clk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe), .main_bank_sinks(mb),
        .sub_bank_sinks(sb), .keypad_sink(ks), .keypad_scale(kc), .pump_gain_high(pg),
        .bus_busy(busy));
    task automatic cmp(input logic [15:0] e, input logic [15:0] o);
        n_checks++;
        if (e !== o) begin error_cnt++; $display("ERROR t=%0t exp=%h got=%h", $time, e, o); end
    endtask
    always @(posedge clk) begin
        if (done) cmp(exp_q.pop_front(), {13'h0, acks});
        if (mv) cmp(exp_q.pop_front(), mval);
    end
    task automatic wr(input logic [7:0] a, r, v, input logic [2:0] ea);
        exp_q.push_back({13'h0, ea});
        ctl.xfer({a, r, v}, 3, 1'b1);
    endtask
    task automatic ms(input logic [15:0] e);
        int cm, cs;
        cm = 0; cs = 0;
        repeat (40) @(posedge clk);
        repeat (32) begin @(posedge clk); cm += mb; cs += sb; end
        exp_q.push_back(e);
        mval <= {pg, ks, kc, cm[5:0], cs[5:0]};
        mv <= 1'b1; @(posedge clk); mv <= 1'b0;
    endtask
    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin repeat (60000) @(posedge clk); error_cnt++; results(); end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        ms(16'h0);
        d = $random(seed);
        wr(8'h56, 8'h10, 8'h03, 3'h7);
        wr(8'h56, 8'hA0, d, 3'h7);
        ms({4'h0, 6'(2 * d[3:0] + 2), 6'(2 * d[7:4] + 2)});
        wr(8'h56, 8'h10, 8'h04, 3'h7);
        for (int k = 0; k < 4; k++) begin
            wr(8'h56, 8'hB0, {6'h3F, 2'(k)}, 3'h7);
            ms({2'b11, 2'(k), 12'h0});
        end
        wr(8'h58, 8'h10, 8'h00, 3'h0);
        wr(8'h57, 8'h10, 8'h00, 3'h0);
        ms({4'hF, 12'h0});
        exp_q.push_back(16'h6);
        ctl.xfer({8'h56, 8'hB0, 8'h00}, 2, 1'b0);
        wr(8'h56, 8'h10, 8'h01, 3'h7);
        ms({4'h3, 6'(2 * d[3:0] + 2), 6'h0});
        results();
    end
endmodule // tb
`default_nettype wire
